// ---- speed_pkg.sv ----
// Contract
// - device holds sixteen preset frequencies, one slot per speed number 0 to 15.
// - binary mode forms a four-bit index, first select is bit 0, fourth bit 3.
// - each binary select function (codes 02 to 05) maps to any of eight inputs.
// - an unassigned binary select bit reads as zero.
// - terminal source with all assigned selects off uses the terminal reference.
// - any assigned select active replaces the reference with the indexed preset.
// - programming by selects needs run off; display then shows the selected preset.
// - an edited preset is written into its slot only on a store action.
// - a preset above the maximum frequency setting never takes effect; the code clamps it to that maximum instead.
// - the output frequency monitor reports the actual output frequency continuously.
// - bit-level mode uses seven one-hot selects for eight speeds; none active is 0.
// - in bit-level mode the lowest-numbered active select wins.
// - bit-level selection is used only when the method setting equals 01.
package speed_pkg;
   localparam int FREQ_W = 16;
   localparam int NUM_PRESETS = 16;
   localparam int IDX_W = 4;
   localparam int NUM_TERMINALS = 8;
   localparam int TERM_SEL_W = 3;
   localparam int NUM_BIN_SEL = 4;
   localparam int NUM_ONEHOT = 7;
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [1:0] METHOD_BINARY = 2'h0;
   localparam logic [1:0] METHOD_BITLEVEL = 2'h1;
   localparam logic [FREQ_W-1:0] PRESET_RESET = 16'h0000;
   localparam logic [FREQ_W-1:0] MAX_FREQ_RESET = 16'h1388;

   // where one select function sits on the terminal block
   typedef struct packed {
      logic assigned;
      logic [TERM_SEL_W-1:0] terminal;
   } sel_map_t;

   // one edit toward the preset table
   typedef struct packed {
      logic store;
      logic [FREQ_W-1:0] value;
   } preset_edit_t;
endpackage : speed_pkg

// ---- preset_mem.sv ----
module preset_mem
   import speed_pkg::*;
#(
   parameter int DEPTH = NUM_PRESETS,
   parameter int AW = IDX_W,
   parameter int DW = FREQ_W
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] slot_r [DEPTH];

   // one stored word per speed number
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            slot_r[i] <= DW'(PRESET_RESET);
         end
      end else if (clk_en_in && wr_en_in) begin
         slot_r[wr_addr_in] <= wr_data_in;
      end
   end

   // registered read port
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rd_data_out <= '0;
      end else if (clk_en_in) begin
         rd_data_out <= slot_r[rd_addr_in];
      end
   end
endmodule : preset_mem

// ---- multi_speed_select.sv ----
module multi_speed_select
   import speed_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic [NUM_TERMINALS-1:0] terminal_in,
   input wire sel_map_t [NUM_BIN_SEL-1:0] bin_map_in,
   input wire sel_map_t [NUM_ONEHOT-1:0] onehot_map_in,
   input wire logic [1:0] select_method_setting_in,
   input wire logic [1:0] freq_source_setting_in,
   input wire logic [FREQ_W-1:0] max_frequency_setting_in,
   input wire logic [FREQ_W-1:0] terminal_ref_in,
   input wire logic [FREQ_W-1:0] alt_ref_in,
   input wire logic run_cmd_in,
   input wire preset_edit_t edit_in,
   output logic [FREQ_W-1:0] freq_cmd_out,
   output logic [FREQ_W-1:0] output_freq_monitor_out,
   output logic [FREQ_W-1:0] freq_setpoint_display_out,
   output logic [IDX_W-1:0] speed_index_out,
   output logic preset_active_out
);
   logic [NUM_TERMINALS-1:0] term_meta_r;
   logic [NUM_TERMINALS-1:0] term_sync_r;
   logic [IDX_W-1:0] idx_r;
   logic [IDX_W-1:0] idx_nxt;
   logic active_r;
   logic active_nxt;
   logic [NUM_BIN_SEL-1:0] bin_bits;
   logic [NUM_ONEHOT-1:0] onehot_bits;
   logic [IDX_W-1:0] onehot_idx;
   logic use_bitlevel;
   logic [FREQ_W-1:0] preset_rd;
   logic [FREQ_W-1:0] raw_cmd;
   logic [FREQ_W-1:0] freq_nxt;
   logic store_ok;
   // store forwarding and output selection
   logic stopped;
   logic fwd_r;
   logic fwd_nxt;
   logic [FREQ_W-1:0] fwd_val_r;
   logic [FREQ_W-1:0] preset_view;
   logic [FREQ_W-1:0] display_nxt;
   logic [FREQ_W-1:0] sel_ref;
   logic src_terminal;
   logic over_max;

   // value of one mapped select function; unassigned reads as zero
   function automatic logic mapped_bit(input sel_map_t m,
                                       input logic [NUM_TERMINALS-1:0] t);
      mapped_bit = m.assigned & t[m.terminal];
   endfunction : mapped_bit

   // first stage of the pin synchroniser; only the second stage reads it
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         term_meta_r <= '0;
      end else if (clk_en_in) begin
         term_meta_r <= terminal_in;
      end
   end

   // second stage; all select decoding starts from here
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         term_sync_r <= '0;
      end else if (clk_en_in) begin
         term_sync_r <= term_meta_r;
      end
   end

   // route binary select functions from any terminal
   genvar g;
   generate
      for (g = 0; g < NUM_BIN_SEL; g++) begin : g_bin
         assign bin_bits[g] = mapped_bit(bin_map_in[g], term_sync_r);
      end
   endgenerate

   // route one-hot select functions from any terminal
   generate
      for (g = 0; g < NUM_ONEHOT; g++) begin : g_hot
         assign onehot_bits[g] = mapped_bit(onehot_map_in[g], term_sync_r);
      end
   endgenerate

   // lowest-numbered active one-hot select wins; none gives speed 0
   always_comb begin
      onehot_idx = '0;
      for (int i = NUM_ONEHOT - 1; i >= 0; i--) begin
         if (onehot_bits[i]) begin
            onehot_idx = IDX_W'(i + 1);
         end
      end
   end

   // decode only by the chosen method
   assign use_bitlevel = (select_method_setting_in == METHOD_BITLEVEL);
   assign idx_nxt = use_bitlevel ? onehot_idx : bin_bits;

   // override is on when any select of the chosen method is on
   assign active_nxt = use_bitlevel ? |onehot_bits : |bin_bits;

   // index updates only on a clock edge
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         idx_r <= '0;
      end else if (clk_en_in) begin
         idx_r <= idx_nxt;
      end
   end

   // override flag moves with the index so both agree in every cycle
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         active_r <= 1'b0;
      end else if (clk_en_in) begin
         active_r <= active_nxt;
      end
   end

   // stores only while stopped, only into the selected slot
   assign stopped = ~run_cmd_in;
   assign store_ok = edit_in.store & stopped;
   // a store into the slot being read would read back stale for a cycle
   assign fwd_nxt = store_ok & (idx_nxt == idx_r);

   // remembers that the last edge wrote the slot now being read
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         fwd_r <= 1'b0;
      end else if (clk_en_in) begin
         fwd_r <= fwd_nxt;
      end
   end

   // value just written, shown in place of the stale read
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         fwd_val_r <= '0;
      end else if (clk_en_in) begin
         fwd_val_r <= edit_in.value;
      end
   end

   // one slot per speed number, read data registered
   preset_mem #(
      .DEPTH(NUM_PRESETS),
      .AW(IDX_W),
      .DW(FREQ_W)
   ) u_presets (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .wr_en_in(store_ok),
      .wr_addr_in(idx_r),
      .wr_data_in(edit_in.value),
      .rd_addr_in(idx_nxt),
      .rd_data_out(preset_rd)
   );

   // the read port is addressed by idx_nxt so it lines up with idx_r, as does the forwarded store
   assign preset_view = fwd_r ? fwd_val_r : preset_rd;

   // preset overrides the terminal reference when any select is on
   assign src_terminal = (freq_source_setting_in == SRC_TERMINAL);
   assign sel_ref = active_r ? preset_view : terminal_ref_in;
   assign raw_cmd = src_terminal ? sel_ref : alt_ref_in;

   // clamp to the ceiling rather than refuse the preset
   assign over_max = (raw_cmd > max_frequency_setting_in);
   assign freq_nxt = over_max ? max_frequency_setting_in : raw_cmd;

   // the display shows the edit while it is stored, else the selected preset
   assign display_nxt = store_ok ? edit_in.value : preset_view;

   // commanded frequency after the ceiling
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         freq_cmd_out <= '0;
      end else if (clk_en_in) begin
         freq_cmd_out <= freq_nxt;
      end
   end

   // monitor shows the very frequency being commanded
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         output_freq_monitor_out <= '0;
      end else if (clk_en_in) begin
         output_freq_monitor_out <= freq_nxt;
      end
   end

   // setpoint display for editing presets
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         freq_setpoint_display_out <= '0;
      end else if (clk_en_in) begin
         freq_setpoint_display_out <= display_nxt;
      end
   end

   // decoded speed number, one edge behind the internal index
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         speed_index_out <= '0;
      end else if (clk_en_in) begin
         speed_index_out <= idx_r;
      end
   end

   // override flag, aligned with the speed number
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         preset_active_out <= 1'b0;
      end else if (clk_en_in) begin
         preset_active_out <= active_r;
      end
   end
endmodule : multi_speed_select

// ---- msel_props.sv ----
module msel_props
   import speed_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic [1:0] select_method_setting_in,
   input wire logic [15:0] max_frequency_setting_in,
   input wire logic run_cmd_in,
   input wire preset_edit_t edit_in,
   input wire logic [15:0] freq_cmd_out,
   input wire logic [15:0] output_freq_monitor_out,
   input wire logic [15:0] freq_setpoint_display_out,
   input wire logic [3:0] speed_index_out,
   input wire logic preset_active_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // outputs tied back to their causes
   property p_mon; output_freq_monitor_out == freq_cmd_out; endproperty
   a_mon: assert property (p_mon) else $error("monitor off");
   property p_max; clk_en_in |=> freq_cmd_out <= $past(max_frequency_setting_in); endproperty
   a_max: assert property (p_max) else $error("above max");
   property p_idle; !preset_active_out |-> speed_index_out == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("idle index");
   property p_act; preset_active_out |-> speed_index_out != 4'h0; endproperty
   a_act: assert property (p_act) else $error("active index");
   property p_bit; (select_method_setting_in == METHOD_BITLEVEL)[*5] |-> speed_index_out < 4'h8;
   endproperty
   a_bit: assert property (p_bit) else $error("bit-level range");
   property p_store; clk_en_in && edit_in.store && !run_cmd_in |=>
      freq_setpoint_display_out == $past(edit_in.value); endproperty
   a_store: assert property (p_store) else $error("store lost");
   property p_fz; !clk_en_in |=> $stable(speed_index_out) && $stable(preset_active_out); endproperty
   a_fz: assert property (p_fz) else $error("index moved");
   property p_fzf; !clk_en_in |=> $stable(freq_cmd_out); endproperty
   a_fzf: assert property (p_fzf) else $error("freq moved");
endmodule : msel_props

// ---- switch_bank.sv ----
module switch_bank
   import speed_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [NUM_TERMINALS-1:0] press_in,
   output logic [NUM_TERMINALS-1:0] terminal_out = '0
);
   timeunit 1ns;
   timeprecision 1ns;
   // contacts settle a clock after asked; selects fill from the low bit
   always @(posedge core_clk_in) terminal_out <= #1 press_in;
endmodule : switch_bank

// ---- tb.sv ----
module tb
   import speed_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, run_cmd_in = 1'b0, preset_active_out;
   logic [1:0] select_method_setting_in = METHOD_BINARY, freq_source_setting_in = SRC_TERMINAL;
   logic [15:0] max_frequency_setting_in = MAX_FREQ_RESET, terminal_ref_in = 16'h0100;
   logic [15:0] alt_ref_in = 16'h0200, freq_cmd_out, output_freq_monitor_out;
   logic [15:0] freq_setpoint_display_out;
   logic [3:0] speed_index_out;
   logic [7:0] press = 8'h00;
   wire logic [7:0] terminal_in;
   sel_map_t [3:0] bin_map_in = 16'h0A98;
   sel_map_t [6:0] onehot_map_in = 28'hEDCBA98;
   preset_edit_t edit_in = '0;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   multi_speed_select u_dut (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .clk_en_in(clk_en_in),
      .terminal_in(terminal_in),
      .bin_map_in(bin_map_in),
      .onehot_map_in(onehot_map_in),
      .select_method_setting_in(select_method_setting_in),
      .freq_source_setting_in(freq_source_setting_in),
      .max_frequency_setting_in(max_frequency_setting_in),
      .terminal_ref_in(terminal_ref_in),
      .alt_ref_in(alt_ref_in),
      .run_cmd_in(run_cmd_in),
      .edit_in(edit_in),
      .freq_cmd_out(freq_cmd_out),
      .output_freq_monitor_out(output_freq_monitor_out),
      .freq_setpoint_display_out(freq_setpoint_display_out),
      .speed_index_out(speed_index_out),
      .preset_active_out(preset_active_out)
   );
   switch_bank u_sw (.core_clk_in(core_clk_in), .press_in(press), .terminal_out(terminal_in));
   initial forever #10 core_clk_in = ~core_clk_in;
   // a hang counts as a mismatch
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic pick(input logic [7:0] p);
      press = p;
      tick(7);
   endtask : pick
   task automatic store(input logic [15:0] v);
      edit_in = '{1'b1, v};
      tick(1);
      edit_in.store = 1'b0;
   endtask : store
   // stimulus sequence
   initial begin
      tick(10);
      reset_in = 1'b0;
      tick(3);
      check(freq_cmd_out, 16'h0100);
      for (int i = 1; i < 8; i++) begin
         pick(8'(i));
         check(freq_setpoint_display_out, PRESET_RESET);
         store(16'h1000 + 16'(i));
         check(freq_setpoint_display_out, 16'h1000 + 16'(i));
         tick(2);
         check(freq_cmd_out, 16'h1000 + 16'(i));
         check(output_freq_monitor_out, 16'h1000 + 16'(i));
         check(16'(preset_active_out), 16'h0001);
         check(16'(speed_index_out), 16'(i));
      end
      $display("binary presets done");
      pick(8'h08);
      check(freq_cmd_out, 16'h0100);
      check(16'(preset_active_out), 16'h0000);
      bin_map_in[3] = 4'hB;
      pick(8'h0F);
      store(16'h100F);
      tick(2);
      check(freq_cmd_out, 16'h100F);
      check(16'(speed_index_out), 16'h000F);
      pick(8'h01);
      run_cmd_in = 1'b1;
      store(16'h0ABC);
      run_cmd_in = 1'b0;
      edit_in.value = 16'h0DDD;
      tick(2);
      check(freq_setpoint_display_out, 16'h1001);
      store(16'hFFFF);
      tick(2);
      check(freq_cmd_out, MAX_FREQ_RESET);
      bin_map_in[0] = 4'hF;
      pick(8'h80);
      check(16'(speed_index_out), 16'h0001);
      $display("store and map done");
      select_method_setting_in = METHOD_BITLEVEL;
      pick(8'h06);
      check(16'(speed_index_out), 16'h0002);
      pick(8'h40);
      check(freq_cmd_out, 16'h1007);
      pick(8'h00);
      check(freq_cmd_out, 16'h0100);
      select_method_setting_in = 2'h2;
      pick(8'h06);
      check(16'(speed_index_out), 16'h0006);
      freq_source_setting_in = 2'h0;
      tick(3);
      check(freq_cmd_out, 16'h0200);
      clk_en_in = 1'b0;
      press = 8'h01;
      tick(6);
      check(16'(speed_index_out), 16'h0006);
      clk_en_in = 1'b1;
      tick(3);
      check(16'(speed_index_out), 16'h0006);
      tick(1);
      check(16'(speed_index_out), 16'h0000);
      $display("bit-level and source done");
      report_and_stop();
   end
endmodule : tb
bind multi_speed_select msel_props u_props (
   .core_clk_in(core_clk_in),
   .reset_in(reset_in),
   .clk_en_in(clk_en_in),
   .select_method_setting_in(select_method_setting_in),
   .max_frequency_setting_in(max_frequency_setting_in),
   .run_cmd_in(run_cmd_in),
   .edit_in(edit_in),
   .freq_cmd_out(freq_cmd_out),
   .output_freq_monitor_out(output_freq_monitor_out),
   .freq_setpoint_display_out(freq_setpoint_display_out),
   .speed_index_out(speed_index_out),
   .preset_active_out(preset_active_out)
);
